// [logic/irhc_defs.svh]
`ifndef IRHC_DEFS_SVH
`define IRHC_DEFS_SVH

// Object index space: bits [15:8] pick the object, [7:0] the subindex
`define IRHC_OBJ_ROUTE        8'h42
`define IRHC_OBJ_CAPTURE      8'h43
`define IRHC_OBJ_CONFIG       8'h40
`define IRHC_SUB_COUNT        8'h00
`define IRHC_SUB_ROUTE_FIRST  8'h01
`define IRHC_SUB_ROUTE_LAST   8'h24
`define IRHC_SUB_CAP_EDGE     8'h01
`define IRHC_SUB_CAP_COUNT    8'h02
`define IRHC_SUB_CAP_USER     8'h03
`define IRHC_SUB_CAP_RAW      8'h04
`define IRHC_SUB_ROUTE_EN     8'h08

// Reset and read-only values
`define IRHC_ROUTE_COUNT_VAL  8'h24
`define IRHC_CAP_ENTRIES_VAL  8'h04
`define IRHC_ROUTE_RESET      8'h00
`define IRHC_WORD_RESET       32'h00000000

// Source code fields
`define IRHC_CODE_INV_BIT     7
`define IRHC_CODE_ZERO        7'h00
`define IRHC_CODE_PHYS_FIRST  7'h01
`define IRHC_CODE_PHYS_LAST   7'h10
`define IRHC_CODE_AUX_FIRST   7'h41
`define IRHC_CODE_AUX_LAST    7'h47

// Edge select encodings
`define IRHC_EDGE_OFF         2'h0
`define IRHC_EDGE_RISE        2'h1
`define IRHC_EDGE_FALL        2'h2
`define IRHC_EDGE_BOTH        2'h3

// Status bit fed by the home switch under conventional mapping
`define IRHC_HOME_BIT         2

`endif

// [logic/irhc_pkg.sv]
package irhc_pkg;

    // Register access request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] index;
        logic [31:0] wdata;
    } irhc_req_s;

    // Auxiliary sensor lines, ordered as codes 41h..47h
    typedef struct packed {
        logic usb_power;
        logic enc_index;
        logic enc_b;
        logic enc_a;
        logic hall_w;
        logic hall_v;
        logic hall_u;
    } irhc_aux_s;

    // Capture unit state
    typedef enum logic [1:0] {
        IRHC_CAP_IDLE  = 2'b01,
        IRHC_CAP_ARMED = 2'b10
    } irhc_cap_state_e;

endpackage

// [logic/irhc_route_mux.sv]
`timescale 1ns/10ps
`include "irhc_defs.svh"

// One routing selector: decodes an 8-bit source code into a single bit
module irhc_route_mux
    import irhc_pkg::*;
#(
    parameter int NUM_PHYS = 16
) (
    input  wire logic [7:0]          code_i,   // Source code
    input  wire logic [NUM_PHYS-1:0] phys_i,   // Physical inputs 1..N
    input  wire irhc_aux_s           aux_i,    // Hall, encoder, USB sense
    output logic                     bit_o     // Routed bit
);
    wire [6:0] sel      = code_i[6:0];
    wire       inv      = code_i[`IRHC_CODE_INV_BIT];
    wire [6:0] phys_off = sel - `IRHC_CODE_PHYS_FIRST;
    wire [6:0] aux_off  = sel - `IRHC_CODE_AUX_FIRST;
    wire [6:0] aux_vec  = aux_i;
    wire       is_zero  = (sel == `IRHC_CODE_ZERO);
    wire       is_phys  = (sel >= `IRHC_CODE_PHYS_FIRST) && (sel <= `IRHC_CODE_PHYS_LAST);
    wire       is_aux   = (sel >= `IRHC_CODE_AUX_FIRST) && (sel <= `IRHC_CODE_AUX_LAST);
    wire       phys_bit = phys_i[phys_off[3:0]];
    wire       aux_bit  = aux_vec[aux_off[2:0]];
    wire       raw      = is_phys ? phys_bit : (is_aux ? aux_bit : 1'b0);

    // Top bit inverts; constants and unknown codes give zero/one or zero
    assign bit_o = is_zero ? inv :
                   (is_phys || is_aux) ? (raw ^ inv) :
                   1'b0;
endmodule

// [logic/irhc_edge_capture.sv]
`timescale 1ns/10ps
`include "irhc_defs.svh"

// Home-switch synchroniser and edge qualifier
module irhc_edge_capture
    import irhc_pkg::*;
(
    input  wire logic       sys_clk_i,  // System clock
    input  wire logic       rst_i,      // Async reset, active high
    input  wire logic       home_i,     // Home switch level
    input  wire logic [1:0] edge_i,     // Edge select
    output logic            event_o     // One-cycle capture event
);
    logic sync1;
    logic sync2;
    logic prev;

    // Two-stage synchroniser plus one history stage
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            prev  <= 1'b0;
        end else begin
            sync1 <= home_i;
            sync2 <= sync1;
            prev  <= sync2;
        end
    end

    wire rise = sync2 & ~prev;
    wire fall = ~sync2 & prev;

    // Edge qualification by selector
    assign event_o = (edge_i == `IRHC_EDGE_RISE) ? rise :
                     (edge_i == `IRHC_EDGE_FALL) ? fall :
                     (edge_i == `IRHC_EDGE_BOTH) ? (rise | fall) :
                     1'b0;
endmodule

// [logic/irhc_input_routing.sv]
`timescale 1ns/10ps
`include "irhc_defs.svh"

module irhc_input_routing
    import irhc_pkg::*;
#(
    parameter int NUM_SEL  = 36,
    parameter int NUM_PHYS = 16
) (
    input  wire logic                sys_clk_i,      // System clock, 10 MHz
    input  wire logic                rst_i,          // Async reset, active high
    input  wire irhc_req_s           req_i,          // Register access request
    output logic [31:0]              rdata_o,        // Read data, registered
    output logic                     ack_o,          // Access done, one cycle
    input  wire logic [NUM_PHYS-1:0] phys_i,         // Physical inputs 1..N
    input  wire irhc_aux_s           aux_i,          // Hall, encoder, USB sense
    input  wire logic [31:0]         pos_user_i,     // Actual position, user units
    input  wire logic [31:0]         pos_raw_i,      // Raw encoder position
    output logic [NUM_SEL-1:0]       input_status_word_o, // Status word
    output logic                     capture_o       // Capture event pulse
);
    logic [7:0]         route_sel [NUM_SEL];
    logic               route_en;
    logic [1:0]         edge_sel;
    logic [31:0]        cap_count;
    logic [31:0]        cap_user;
    logic [31:0]        cap_raw;
    irhc_cap_state_e    cap_state;
    irhc_cap_state_e    next_cap_state;
    logic [NUM_SEL-1:0] routed;
    logic               cap_event;

    // Address decode
    wire [7:0] obj        = req_i.index[15:8];
    wire [7:0] sub        = req_i.index[7:0];
    wire       hit_route  = (obj == `IRHC_OBJ_ROUTE);
    wire       hit_cap    = (obj == `IRHC_OBJ_CAPTURE);
    wire       hit_cfg    = (obj == `IRHC_OBJ_CONFIG);
    wire       sel_range  = hit_route && (sub >= `IRHC_SUB_ROUTE_FIRST)
                            && (sub <= `IRHC_SUB_ROUTE_LAST);
    wire [7:0] sel_idx    = sub - `IRHC_SUB_ROUTE_FIRST;
    wire       wr_route   = req_i.wr && sel_range;
    wire       wr_edge    = req_i.wr && hit_cap && (sub == `IRHC_SUB_CAP_EDGE);
    wire       wr_count   = req_i.wr && hit_cap && (sub == `IRHC_SUB_CAP_COUNT);
    wire       wr_user    = req_i.wr && hit_cap && (sub == `IRHC_SUB_CAP_USER);
    wire       wr_raw     = req_i.wr && hit_cap && (sub == `IRHC_SUB_CAP_RAW);
    wire       wr_ren     = req_i.wr && hit_cfg && (sub == `IRHC_SUB_ROUTE_EN);
    wire [1:0] new_edge   = req_i.wdata[1:0];
    wire       start_cap  = wr_edge && (new_edge != `IRHC_EDGE_OFF);

    // One decoder per status bit
    genvar g;
    generate
        for (g = 0; g < NUM_SEL; g++) begin : g_route
            irhc_route_mux #(
                .NUM_PHYS (NUM_PHYS)
            ) u_mux (
                .code_i (route_sel[g]),
                .phys_i (phys_i),
                .aux_i  (aux_i),
                .bit_o  (routed[g])
            );

            // Selector storage
            always_ff @(posedge sys_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    route_sel[g] <= `IRHC_ROUTE_RESET;
                end else if (wr_route && (sel_idx == 8'(g))) begin
                    route_sel[g] <= req_i.wdata[7:0];
                end
            end
        end
    endgenerate

    // Conventional mapping: physical inputs straight to low bits, normally open
    logic [NUM_SEL-1:0] conv_word;
    always_comb begin
        conv_word = '0;
        for (int i = 0; i < NUM_PHYS && i < NUM_SEL; i++) begin
            conv_word[i] = phys_i[i];
        end
    end

    // Routing enable selects the status word source
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            input_status_word_o <= '0;
        end else begin
            input_status_word_o <= route_en ? routed : conv_word;
        end
    end

    // Routing enable register
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            route_en <= 1'b0;
        end else if (wr_ren) begin
            route_en <= req_i.wdata[0];
        end
    end

    // Home switch is the conventional home bit
    wire home_level = phys_i[`IRHC_HOME_BIT];

    irhc_edge_capture u_edge (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .home_i    (home_level),
        .edge_i    (edge_sel),
        .event_o   (cap_event)
    );

    // Capture state: armed while an edge mode is selected
    always_comb begin
        next_cap_state = cap_state;
        unique case (cap_state)
            IRHC_CAP_IDLE: begin
                if (start_cap) begin
                    next_cap_state = IRHC_CAP_ARMED;
                end
            end
            IRHC_CAP_ARMED: begin
                if (wr_edge && !start_cap) begin
                    next_cap_state = IRHC_CAP_IDLE;
                end
            end
            default: begin
                next_cap_state = IRHC_CAP_IDLE;
            end
        endcase
    end

    // A capture needs armed state and no edge-select write this cycle
    wire do_capture = (cap_state == IRHC_CAP_ARMED) && cap_event && !wr_edge;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cap_state <= IRHC_CAP_IDLE;
            edge_sel  <= `IRHC_EDGE_OFF;
        end else begin
            cap_state <= next_cap_state;
            if (wr_edge) begin
                edge_sel <= new_edge;
            end
        end
    end

    // Capture counter: start clears it, each capture adds one
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cap_count <= `IRHC_WORD_RESET;
        end else if (start_cap) begin
            cap_count <= `IRHC_WORD_RESET;
        end else if (do_capture) begin
            cap_count <= cap_count + 32'h00000001;
        end else if (wr_count) begin
            cap_count <= req_i.wdata;
        end
    end

    // Captured positions; capture wins over a software write
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cap_user <= `IRHC_WORD_RESET;
            cap_raw  <= `IRHC_WORD_RESET;
        end else begin
            if (do_capture) begin
                cap_user <= pos_user_i;
            end else if (wr_user) begin
                cap_user <= req_i.wdata;
            end
            if (do_capture) begin
                cap_raw <= pos_raw_i;
            end else if (wr_raw) begin
                cap_raw <= req_i.wdata;
            end
        end
    end

    // Read multiplexer
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        if (hit_route && sub == `IRHC_SUB_COUNT) begin
            rd_mux = {24'h000000, `IRHC_ROUTE_COUNT_VAL};
        end else if (sel_range) begin
            rd_mux = {24'h000000, route_sel[sel_idx[5:0]]};
        end else if (hit_cap) begin
            unique case (sub)
                `IRHC_SUB_COUNT:     rd_mux = {24'h000000, `IRHC_CAP_ENTRIES_VAL};
                `IRHC_SUB_CAP_EDGE:  rd_mux = {30'h00000000, edge_sel};
                `IRHC_SUB_CAP_COUNT: rd_mux = cap_count;
                `IRHC_SUB_CAP_USER:  rd_mux = cap_user;
                `IRHC_SUB_CAP_RAW:   rd_mux = cap_raw;
                default:             rd_mux = 32'h00000000;
            endcase
        end else if (hit_cfg && sub == `IRHC_SUB_ROUTE_EN) begin
            rd_mux = {31'h00000000, route_en};
        end
    end

    // Registered read data and one-cycle acknowledge
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o   <= 32'h00000000;
            ack_o     <= 1'b0;
            capture_o <= 1'b0;
        end else begin
            ack_o     <= req_i.wr | req_i.rd;
            capture_o <= do_capture;
            if (req_i.rd) begin
                rdata_o <= rd_mux;
            end
        end
    end
endmodule

// [testbench/irhc_monitor.sv]
`timescale 1ns/10ps
module irhc_monitor
    import irhc_pkg::*;
#(
    parameter int NUM_SEL  = 36,
    parameter int NUM_PHYS = 16
) (
    input wire logic                sys_clk_i,  // Clock
    input wire logic                rst_i,      // Reset
    input wire irhc_req_s           req_i,      // Request
    input wire logic [31:0]         rdata_o,    // Read data
    input wire logic                ack_o,      // Done
    input wire logic [NUM_PHYS-1:0] phys_i,     // Inputs
    input wire irhc_aux_s           aux_i,      // Sensors
    input wire logic [31:0]         pos_user_i, // User pos
    input wire logic [31:0]         pos_raw_i,  // Raw pos
    input wire logic [NUM_SEL-1:0]  input_status_word_o, // Status
    input wire logic                capture_o   // Capture
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    logic [1:0] edge_q;
    logic       home;
    logic       edge_wr;
    // Home level and edge-select writes
    assign home    = phys_i[2];
    assign edge_wr = req_i.wr && (req_i.index == 16'h4301);
    // Mirror of the edge select
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) edge_q <= 2'h0;
        else if (edge_wr) edge_q <= req_i.wdata[1:0];
    end
    a_ack_after_req: assert property ((req_i.wr || req_i.rd) |=> ack_o)
        else $error("no ack after request");
    a_ack_has_cause: assert property (ack_o |-> $past(req_i.wr || req_i.rd))
        else $error("ack without request");
    a_sel_count: assert property (req_i.rd && req_i.index == 16'h4200 |=> rdata_o == 32'h24)
        else $error("selector count wrong");
    a_reset_zero: assert property ($fell(rst_i) |-> input_status_word_o == '0)
        else $error("status not zero after reset");
    a_rise_capture: assert property (($rose(home) && edge_q[0] && !edge_wr) ##1 (!edge_wr)[*3] |-> ##[0:1] capture_o)
        else $error("rising edge missed");
    a_fall_capture: assert property (($fell(home) && edge_q[1] && !edge_wr) ##1 (!edge_wr)[*3] |-> ##[0:1] capture_o)
        else $error("falling edge missed");
    a_cap_cause: assert property (capture_o |-> $past(home, 3) != $past(home, 4) || $past(home, 4) != $past(home, 5))
        else $error("capture without home change");
    a_cap_when_on: assert property (capture_o |-> ($past(edge_q, 1) | $past(edge_q, 2) | $past(edge_q, 3)) != 2'h0)
        else $error("capture while disabled");
    c_rise: cover property (capture_o && edge_q == 2'h1);
    c_both: cover property (capture_o && edge_q == 2'h3);
    c_last_sel: cover property (req_i.wr && req_i.index == 16'h4224);
endmodule

bind irhc_input_routing irhc_monitor #(.NUM_SEL(NUM_SEL), .NUM_PHYS(NUM_PHYS)) i_irhc_monitor (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o), .ack_o(ack_o),
    .phys_i(phys_i), .aux_i(aux_i), .pos_user_i(pos_user_i), .pos_raw_i(pos_raw_i),
    .input_status_word_o(input_status_word_o), .capture_o(capture_o));

// [testbench/irhc_sensor_model.sv]
`timescale 1ns/10ps
module irhc_sensor_model
    import irhc_pkg::*;
(
    input  wire logic        sys_clk_i,  // Clock
    input  wire logic        home_i,     // Home switch level
    input  wire logic [15:0] lvl_i,      // Switch levels
    input  wire irhc_aux_s   aux_set_i,  // Sensor levels
    input  wire logic        step_i,     // Encoder moves
    output logic [15:0]      phys_o,     // Physical inputs
    output irhc_aux_s        aux_o,      // Sensor lines
    output logic [31:0]      pos_user_o, // User position
    output logic [31:0]      pos_raw_o   // Raw count
);
    logic [15:0] phys_q = 16'h0000;
    irhc_aux_s   aux_q  = 7'h00;
    logic [31:0] cnt    = 32'h00001000;
    // Lines follow commands one edge later; high level reads as 1
    always @(posedge sys_clk_i) begin
        phys_q <= {lvl_i[15:3], home_i, lvl_i[1:0]};
        aux_q  <= aux_set_i;
        if (step_i) cnt <= cnt + 32'h00000003;
    end
    // One raw count is four user units
    assign phys_o     = phys_q;
    assign aux_o      = aux_q;
    assign pos_raw_o  = cnt;
    assign pos_user_o = {cnt[29:0], 2'h0};
endmodule

// [testbench/tb_irhc_input_routing.sv]
`timescale 1ns/10ps
module tb_irhc_input_routing;
    import irhc_pkg::*;
    logic        sys_clk_i = 1'b0;
    logic        rst_i;
    irhc_req_s   req;
    logic [31:0] rdata, pos_user, pos_raw;
    logic        ack, capture, home, step;
    logic [15:0] phys, lvl;
    irhc_aux_s   aux, aux_set;
    logic [35:0] status;
    int          mismatches = 0, n_tests = 0, ncap = 0, cyc = 0;

    irhc_input_routing i_irhc_input_routing (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .req_i(req), .rdata_o(rdata), .ack_o(ack), .phys_i(phys), .aux_i(aux),
        .pos_user_i(pos_user), .pos_raw_i(pos_raw), .input_status_word_o(status),
        .capture_o(capture));
    irhc_sensor_model i_irhc_sensor_model (.sys_clk_i(sys_clk_i), .home_i(home),
        .lvl_i(lvl), .aux_set_i(aux_set), .step_i(step), .phys_o(phys), .aux_o(aux),
        .pos_user_o(pos_user), .pos_raw_o(pos_raw));

    always #50 sys_clk_i = ~sys_clk_i;
    // Pulse counter and hang guard
    always @(posedge sys_clk_i) begin
        if (capture === 1'b1) ncap <= ncap + 1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [35:0] got, input logic [35:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One access; answer lands on the edge that takes it, one edge after it is driven
    task automatic acc(input logic w, input logic [15:0] idx, input logic [31:0] d,
                       output logic [35:0] q);
        @(posedge sys_clk_i);
        req <= '{wr: w, rd: !w, index: idx, wdata: d};
        @(posedge sys_clk_i);
        req <= '0;
        #1;
        q = {4'h0, rdata};
        chk("ack", {35'h0, ack}, 36'h1);
    endtask

    function automatic logic ref_bit(input logic [7:0] c, input logic [15:0] p,
                                     input irhc_aux_s a);
        logic v;
        v = 1'b0;
        if (c[6:0] >= 7'h01 && c[6:0] <= 7'h10) v = p[c[6:0] - 7'h01];
        else if (c[6:0] >= 7'h41 && c[6:0] <= 7'h47) v = a[c[6:0] - 7'h41];
        else if (c[6:0] != 7'h00) return 1'b0;
        return v ^ c[7];
    endfunction

    // Read-only and reset values, refused write, unmapped read
    task automatic t_reset();
        logic [35:0] q;
        acc(1'b1, 16'h4200, 32'h000000FF, q);
        acc(1'b0, 16'h4200, 32'h0, q);
        chk("selector count", q, 36'h24);
        acc(1'b0, 16'h4300, 32'h0, q);
        chk("capture entries", q, 36'h4);
        for (int s = 1; s <= 36; s++) begin
            acc(1'b0, 16'h4200 + 16'(s), 32'h0, q);
            chk("selector reset", q, 36'h0);
        end
        for (int s = 1; s <= 4; s++) begin
            acc(1'b0, 16'h4300 + 16'(s), 32'h0, q);
            chk("capture reset", q, 36'h0);
        end
        acc(1'b0, 16'h4225, 32'h0, q);
        chk("unmapped", q, 36'h0);
        chk("status reset", status, 36'h0);
    endtask

    // Every code on selector 1 with two patterns, opposite except at home bit 2
    task automatic t_route();
        logic [35:0] q;
        acc(1'b1, 16'h4008, 32'h1, q);
        acc(1'b0, 16'h4008, 32'h0, q);
        chk("route enable", q, 36'h1);
        for (int pass = 0; pass < 2; pass++) begin
            @(posedge sys_clk_i);
            lvl <= pass ? 16'h5A38 : 16'hA5C3;
            aux_set <= pass ? 7'h54 : 7'h2B;
            for (int c = 0; c < 256; c++) begin
                acc(1'b1, 16'h4201, 32'(c), q);
                @(posedge sys_clk_i);
                #1;
                chk("bit0", {35'h0, status[0]}, {35'h0, ref_bit(8'(c), lvl, aux_set)});
            end
        end
        acc(1'b1, 16'h4224, 32'h80, q);
        @(posedge sys_clk_i);
        #1;
        chk("bit35", {35'h0, status[35]}, 36'h1);
        acc(1'b1, 16'h4008, 32'h0, q);
        @(posedge sys_clk_i);
        #1;
        chk("plain map", status, {20'h0, lvl});
    endtask

    // Move the encoder, then change the home level
    task automatic hop(input logic v, input logic want, inout logic [35:0] eu, er);
        int n0;
        @(posedge sys_clk_i);
        step <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        step <= 1'b0;
        @(posedge sys_clk_i);
        #1;
        if (want) eu = {4'h0, pos_user};
        if (want) er = {4'h0, pos_raw};
        n0 = ncap;
        @(posedge sys_clk_i);
        home <= v;
        repeat (7) @(posedge sys_clk_i);
        #1;
        chk("pulses", 36'(ncap - n0), {35'h0, want});
    endtask

    task automatic t_capture();
        logic [35:0] q, eu, er;
        eu = 36'h0;
        er = 36'h0;
        for (int m = 1; m < 4; m++) begin
            acc(1'b1, 16'h4301, 32'(m), q); // no homing run here
            acc(1'b0, 16'h4301, 32'h0, q);
            chk("edge select", q, 36'(m));
            acc(1'b0, 16'h4302, 32'h0, q);
            chk("count clear", q, 36'h0);
            hop(1'b1, m[0], eu, er);
            hop(1'b0, m[1], eu, er);
            acc(1'b0, 16'h4302, 32'h0, q);
            chk("count", q, 36'(m[0] + m[1]));
            acc(1'b0, 16'h4303, 32'h0, q);
            chk("user pos", q, eu);
            acc(1'b0, 16'h4304, 32'h0, q);
            chk("raw pos", q, er);
        end
        acc(1'b1, 16'h4301, 32'h0, q);
        hop(1'b1, 1'b0, eu, er);
        acc(1'b0, 16'h4302, 32'h0, q);
        chk("count kept", q, 36'h2);
    endtask

    initial begin
        rst_i = 1'b1;
        req = '0;
        home = 1'b0;
        lvl = 16'h0000;
        aux_set = 7'h00;
        step = 1'b0;
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_route();
        t_capture();
        summarize();
    end
endmodule
